// *** design/clock_divisor_pkg.sv ***
// Constants for the clock divisor control register block.
// Assumes a single 200 MHz system clock and an AXI4-Lite master.
package clock_divisor_pkg;
  localparam logic [3:0]  ADDR_CONTROL     = 4'h0;
  localparam logic [3:0]  ADDR_INTERRUPT   = 4'h4;
  localparam int          RECOVER_BIT      = 15;
  localparam int          REDUCTION_MSB    = 14;
  localparam int          REDUCTION_LSB    = 12;
  localparam int          PROCESSOR_CLOCK_REDUCTION_EN_BIT      = 11;
  localparam int          POSTSCALER_MSB   = 10;
  localparam int          POSTSCALER_LSB   = 8;
  localparam int          VCO_DIV_MSB      = 7;
  localparam int          VCO_DIV_LSB      = 6;
  localparam logic [15:0] CONTROL_RESET    = 16'h0100;
  localparam logic [15:0] CONTROL_WMASK    = 16'hFFC0;
  localparam logic [2:0]  REDUCTION_NONE   = 3'h0;
  localparam logic [1:0]  AXI_OKAY         = 2'h0;
  localparam logic [1:0]  AXI_SLVERR       = 2'h2;
endpackage : clock_divisor_pkg

// *** design/divide_ratio_decode.sv ***
// Decodes the reduction and postscaler codes into log2 divide ratios.
// Assumes combinational use from registered fields on the same clock.
`timescale 1ns/100ps
module divide_ratio_decode (
  // Codes
  input  wire logic [2:0] reduction_code_in,
  input  wire logic       processor_clock_reduction_enable_in,
  input  wire logic [2:0] postscaler_code_in,
  // Ratios as shift amounts
  output logic      [2:0] cpu_shift_out,
  output logic      [3:0] rc_shift_out
);
  // Processor_clock_reduction off forces 1:1
  assign cpu_shift_out = processor_clock_reduction_enable_in ? reduction_code_in : 3'h0; // (R2) (R3)
  // Code 111 skips 128 and goes to 256
  assign rc_shift_out  = (postscaler_code_in == 3'h7) ? 4'h8 : {1'b0, postscaler_code_in}; // (R6)
endmodule : divide_ratio_decode

// *** design/clock_divisor_control.sv ***
// Clock divisor control register with AXI4-Lite slave access.
// Assumes one clock, asynchronous active-low reset, interrupt pulse from same clock.
// Operation
// (R1) Three-bit processor clock reduction field sits at bits 14 to 12.
// (R2) Reduction codes 001 to 111 divide instruction clock by 2 to 128.
// (R3) Processor_clock_reduction enable clear forces processor to peripheral ratio 1:1.
// (R4) Writes setting processor_clock_reduction enable while reduction is 000 are ignored.
// (R5) Three-bit fast RC postscaler field sits at bits 10 to 8.
// (R6) Postscaler codes 001..110 divide 2..64, code 111 divides by 256.
// (R7) Postscaler resets to 001, divide by two.
// (R8) Recover-on-interrupt set makes any interrupt clear processor_clock_reduction enable.
`timescale 1ns/100ps
module clock_divisor_control (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // Interrupt event from the core
  input  wire logic        interrupt_in,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Clock settings
  output logic [2:0]       cpu_clock_shift_out,
  output logic [3:0]       rc_clock_shift_out,
  output logic [1:0]       vco_output_divider_out,
  output logic             processor_clock_reduction_active_out
);
  logic [15:0] control;
  logic [3:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic [2:0]  cpu_shift;
  logic [3:0]  rc_shift;

  wire         aw_fire    = s_axi_awvalid_in & s_axi_awready_out;
  wire         w_fire     = s_axi_wvalid_in & s_axi_wready_out;
  wire         write_go   = aw_held & w_held & ~s_axi_bvalid_out;
  wire         write_hit  = (aw_addr == clock_divisor_pkg::ADDR_CONTROL);
  wire         ar_fire    = s_axi_arvalid_in & s_axi_arready_out;
  wire         read_hit   = (s_axi_araddr_in == clock_divisor_pkg::ADDR_CONTROL);

  // Byte-lane merge of the control word
  wire  [15:0] lane_mask  = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire  [15:0] merged     = (control & ~lane_mask) | (w_data[15:0] & lane_mask);
  wire  [15:0] writable   = (merged & clock_divisor_pkg::CONTROL_WMASK)
                          | (control & ~clock_divisor_pkg::CONTROL_WMASK);

  // Fields of the merged write word
  wire         wr_recover = writable[clock_divisor_pkg::RECOVER_BIT];
  wire  [2:0]  wr_red     = writable[clock_divisor_pkg::REDUCTION_MSB:clock_divisor_pkg::REDUCTION_LSB];
  wire         wr_processor_clock_reduction    = writable[clock_divisor_pkg::PROCESSOR_CLOCK_REDUCTION_EN_BIT];
  wire  [2:0]  wr_post    = writable[clock_divisor_pkg::POSTSCALER_MSB:clock_divisor_pkg::POSTSCALER_LSB];
  wire  [1:0]  wr_vco     = writable[clock_divisor_pkg::VCO_DIV_MSB:clock_divisor_pkg::VCO_DIV_LSB];
  // Fields as they stand
  wire  [2:0]  cur_red    = control[clock_divisor_pkg::REDUCTION_MSB:clock_divisor_pkg::REDUCTION_LSB];
  wire         cur_processor_clock_reduction   = control[clock_divisor_pkg::PROCESSOR_CLOCK_REDUCTION_EN_BIT];

  // Reduction may change only while processor_clock_reduction is off
  wire  [2:0]  new_red    = cur_processor_clock_reduction ? cur_red : wr_red; // (R1)
  // Field must be nonzero before and after the write, else processor_clock_reduction could
  // land together with a field cleared in the same write
  wire         processor_clock_reduction_ok    = wr_processor_clock_reduction
                          & (cur_red != clock_divisor_pkg::REDUCTION_NONE)
                          & (new_red != clock_divisor_pkg::REDUCTION_NONE); // (R4)
  wire  [15:0] written    = {wr_recover, new_red, processor_clock_reduction_ok, wr_post, wr_vco, control[5:0]}; // (R5)
  wire         write_ctl  = write_go & write_hit;
  wire  [15:0] staged     = write_ctl ? written : control;
  // Interrupt recovery wins over a simultaneous write
  wire         recover    = interrupt_in & control[clock_divisor_pkg::RECOVER_BIT]; // (R8)
  wire  [15:0] next_control = recover ? (staged & ~(16'h0001 << clock_divisor_pkg::PROCESSOR_CLOCK_REDUCTION_EN_BIT)) : staged;

  assign s_axi_awready_out = ~aw_held;
  assign s_axi_wready_out  = ~w_held;
  assign s_axi_arready_out = ~s_axi_rvalid_out;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      control <= clock_divisor_pkg::CONTROL_RESET; // (R7)
    end else begin
      control <= next_control;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (aw_fire) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (write_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (w_fire) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (write_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= clock_divisor_pkg::AXI_OKAY;
    end else if (write_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= write_hit ? clock_divisor_pkg::AXI_OKAY : clock_divisor_pkg::AXI_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= clock_divisor_pkg::AXI_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= read_hit ? {16'h0000, control} : 32'h0000_0000;
      s_axi_rresp_out  <= read_hit ? clock_divisor_pkg::AXI_OKAY : clock_divisor_pkg::AXI_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  divide_ratio_decode u_decode (
    .reduction_code_in  (cur_red),
    .processor_clock_reduction_enable_in     (control[clock_divisor_pkg::PROCESSOR_CLOCK_REDUCTION_EN_BIT]),
    .postscaler_code_in (control[clock_divisor_pkg::POSTSCALER_MSB:clock_divisor_pkg::POSTSCALER_LSB]),
    .cpu_shift_out      (cpu_shift),
    .rc_shift_out       (rc_shift)
  );

  // Settings outputs, each one register behind the control word
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cpu_clock_shift_out <= 3'h0;
    end else begin
      cpu_clock_shift_out <= cpu_shift; // (R2) (R3)
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rc_clock_shift_out <= 4'h1;
    end else begin
      rc_clock_shift_out <= rc_shift; // (R6)
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vco_output_divider_out <= 2'h0;
    end else begin
      vco_output_divider_out <= control[clock_divisor_pkg::VCO_DIV_MSB:clock_divisor_pkg::VCO_DIV_LSB];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      processor_clock_reduction_active_out <= 1'b0;
    end else begin
      processor_clock_reduction_active_out <= cur_processor_clock_reduction;
    end
  end
endmodule : clock_divisor_control

// *** dv/clock_divisor_chk.sv ***
// Port checker for the clock divisor control register.
// Assumes binding onto clock_divisor_control, one clock domain.
`timescale 1ns/100ps
module clock_divisor_chk (
  // Watched ports
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic [3:0]  s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [2:0]  cpu_clock_shift_out,
  input wire logic [3:0]  rc_clock_shift_out,
  input wire logic        processor_clock_reduction_active_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  processor_clock_reduction_off_a: assert property (!processor_clock_reduction_active_out |-> cpu_clock_shift_out == 3'h0)
    else $error("ratio not 1:1 with processor_clock_reduction off");
  processor_clock_reduction_code_a: assert property (processor_clock_reduction_active_out |-> cpu_clock_shift_out != 3'h0)
    else $error("processor_clock_reduction on with code 000");
  ratio_lock_a: assert property (processor_clock_reduction_active_out && $past(processor_clock_reduction_active_out) |-> $stable(cpu_clock_shift_out))
    else $error("ratio moved during processor_clock_reduction");
  rc_range_a: assert property (rc_clock_shift_out inside {[4'h0:4'h6], 4'h8})
    else $error("postscaler ratio illegal");
  read_pad_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0 &&
    s_axi_rdata_out[5:0] == 6'h0) else $error("unused bits read nonzero");
  read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered");
  read_busy_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("address taken while data pending");
  bad_read_a: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in != 4'h0
    |=> s_axi_rresp_out == clock_divisor_pkg::AXI_SLVERR) else $error("unmapped read not refused");
  processor_clock_reduction_seen_c: cover property ($rose(processor_clock_reduction_active_out));
  bad_read_c: cover property (s_axi_rvalid_out && s_axi_rresp_out == clock_divisor_pkg::AXI_SLVERR);
  rc_max_c: cover property (rc_clock_shift_out == 4'h8);
endmodule : clock_divisor_chk

bind clock_divisor_control clock_divisor_chk chk_i (
  .ref_clk_in          (ref_clk_in),
  .rst_b_in            (rst_b_in),
  .s_axi_araddr_in     (s_axi_araddr_in),
  .s_axi_arvalid_in    (s_axi_arvalid_in),
  .s_axi_arready_out   (s_axi_arready_out),
  .s_axi_rdata_out     (s_axi_rdata_out),
  .s_axi_rresp_out     (s_axi_rresp_out),
  .s_axi_rvalid_out    (s_axi_rvalid_out),
  .cpu_clock_shift_out (cpu_clock_shift_out),
  .rc_clock_shift_out  (rc_clock_shift_out),
  .processor_clock_reduction_active_out     (processor_clock_reduction_active_out)
);

// *** dv/clock_divisor_control_bench.sv ***
// Self-checking bench for the clock divisor control register.
// Assumes the package and design are compiled first.
`timescale 1ns/100ps
module clock_divisor_control_bench;
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, interrupt_in = 1'b0, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, got, ta, tw;
  logic [3:0]  s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0, s_axi_wstrb_in = 4'hF, rc_clock_shift_out;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, processor_clock_reduction_active_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, vco_output_divider_out, resp;
  logic [2:0]  cpu_clock_shift_out;
  int          mismatches = 0, tests_run = 0, cycles = 0;
  clock_divisor_control DUT (
    .ref_clk_in             (ref_clk_in),
    .rst_b_in               (rst_b_in),
    .interrupt_in           (interrupt_in),
    .s_axi_awaddr_in        (s_axi_awaddr_in),
    .s_axi_awvalid_in       (s_axi_awvalid_in),
    .s_axi_awready_out      (s_axi_awready_out),
    .s_axi_wdata_in         (s_axi_wdata_in),
    .s_axi_wstrb_in         (s_axi_wstrb_in),
    .s_axi_wvalid_in        (s_axi_wvalid_in),
    .s_axi_wready_out       (s_axi_wready_out),
    .s_axi_bresp_out        (s_axi_bresp_out),
    .s_axi_bvalid_out       (s_axi_bvalid_out),
    .s_axi_bready_in        (s_axi_bready_in),
    .s_axi_araddr_in        (s_axi_araddr_in),
    .s_axi_arvalid_in       (s_axi_arvalid_in),
    .s_axi_arready_out      (s_axi_arready_out),
    .s_axi_rdata_out        (s_axi_rdata_out),
    .s_axi_rresp_out        (s_axi_rresp_out),
    .s_axi_rvalid_out       (s_axi_rvalid_out),
    .s_axi_rready_in        (s_axi_rready_in),
    .cpu_clock_shift_out    (cpu_clock_shift_out),
    .rc_clock_shift_out     (rc_clock_shift_out),
    .vco_output_divider_out (vco_output_divider_out),
    .processor_clock_reduction_active_out        (processor_clock_reduction_active_out)
  );
  always #2.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Readies and answers read at the rising edge itself, before the design's updates land
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    {ta, tw, got} = 3'b110;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {16'h0, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (ta && s_axi_awready_out) begin
        ta = 1'b0;
        s_axi_awvalid_in <= 1'b0;
      end
      if (tw && s_axi_wready_out) begin
        tw = 1'b0;
        s_axi_wvalid_in <= 1'b0;
      end
      {got, resp} = {s_axi_bvalid_out, s_axi_bresp_out};
    end while (!got);
    s_axi_bready_in <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk_in);
    {ta, got} = 2'b10;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (ta && s_axi_arready_out) begin
        ta = 1'b0;
        s_axi_arvalid_in <= 1'b0;
      end
      {got, rd, resp} = {s_axi_rvalid_out, s_axi_rdata_out, s_axi_rresp_out};
    end while (!got);
    s_axi_rready_in <= 1'b0;
  endtask : rd_reg
  task automatic test_postscaler();
    rd_reg(4'h0);
    check(rd, 32'h0000_0100, "reset value");
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, 16'((c << 8) | ((c & 3) << 6) | 16'h003F));
      @(negedge ref_clk_in);
      check(32'(rc_clock_shift_out), (c == 7) ? 32'd8 : 32'(c), "rc ratio");
      check(32'(vco_output_divider_out), 32'(c & 3), "vco divider");
      rd_reg(4'h0);
      check(32'(rd[10:0]), 32'((c << 8) | ((c & 3) << 6)), "postscaler field");
    end
    $display("test done: postscaler");
  endtask : test_postscaler
  task automatic test_reduction();
    for (int c = 1; c < 8; c++) begin
      wr(4'h0, 16'(c << 12));
      @(negedge ref_clk_in);
      check(32'(cpu_clock_shift_out), 32'h0, "forced 1:1");
      wr(4'h0, 16'((c << 12) | 16'h0800));
      @(negedge ref_clk_in);
      check(32'(cpu_clock_shift_out), 32'(c), "processor_clock_reduction ratio");
      rd_reg(4'h0);
      check(32'(rd[14:11]), 32'(c * 2 + 1), "reduction field");
      wr(4'h0, 16'(c << 12));
    end
    $display("test done: reduction");
  endtask : test_reduction
  task automatic test_lock_and_map();
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0800);
    rd_reg(4'h0);
    check(32'({rd[11], processor_clock_reduction_active_out}), 32'h0, "processor_clock_reduction set with 000");
    wr(4'h8, 16'h0800);
    check(32'(resp), 32'(clock_divisor_pkg::AXI_SLVERR), "unmapped write");
    rd_reg(4'h8);
    check({rd[31:2], resp}, {30'h0, clock_divisor_pkg::AXI_SLVERR}, "unmapped read");
    $display("test done: lock and map");
  endtask : test_lock_and_map
  task automatic test_interrupt(input logic recover_on_interrupt);
    wr(4'h0, {recover_on_interrupt, 15'h3000});
    wr(4'h0, {recover_on_interrupt, 15'h3800});
    @(posedge ref_clk_in);
    interrupt_in <= 1'b1;
    @(posedge ref_clk_in);
    interrupt_in <= 1'b0;
    rd_reg(4'h0);
    check(32'(rd[15:11]), 32'({recover_on_interrupt, 3'h3, !recover_on_interrupt}), "processor_clock_reduction after interrupt");
    wr(4'h0, 16'h3000);
    $display("test done: interrupt");
  endtask : test_interrupt
  task automatic test_reset();
    wr(4'h0, 16'hB800);
    @(negedge ref_clk_in);
    check(32'({processor_clock_reduction_active_out, cpu_clock_shift_out}), 32'h0000_000B, "processor_clock_reduction before reset");
    @(posedge ref_clk_in);
    rst_b_in <= 1'b0;
    @(negedge ref_clk_in);
    check(32'({processor_clock_reduction_active_out, cpu_clock_shift_out, rc_clock_shift_out}), 32'h0000_0001, "outputs in reset");
    repeat (6) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    rd_reg(4'h0);
    check(rd, 32'h0000_0100, "value after reset");
    $display("test done: reset");
  endtask : test_reset
  initial begin
    repeat (6) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    test_postscaler();
    test_reduction();
    test_lock_and_map();
    test_interrupt(1'b0);
    test_interrupt(1'b1);
    test_reset();
    end_sim();
  end
endmodule : clock_divisor_control_bench
